// ==== smps_pkg.sv ====
// Package of constants and types for the startup/protection sequencer
package smps_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_EVENTS = 4'h8;
  localparam logic [3:0] REG_TIMER = 4'hc;
  // Control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SOFT_DISABLE_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Default terminal counts of the restart timer unit and the two qualification counters, in clock cycles
  localparam int RAMP_CYCLES = 4096;
  localparam int OVERCURRENT_STOP_CYCLES = 1024;
  localparam int BROWNOUT_QUAL_CYCLES = 2048;
  localparam int OVER_POWER_QUAL_CYCLES = 4096;
  localparam int RESTART_CYCLES = 4096;
  localparam int TIMER_W = 24;
  // Charge source current selection codes
  localparam logic [1:0] CHG_OFF = 2'h0;
  localparam logic [1:0] CHG_REDUCED = 2'h1;
  localparam logic [1:0] CHG_HIGH = 2'h2;

  typedef enum logic [2:0] {
    SMPS_STARTUP,
    SMPS_RAMP,
    SMPS_ACTIVE,
    SMPS_STOP,
    SMPS_LOWC
  } smps_mode_e;
endpackage

// ==== smps_rail_model.sv ====
// Behavioural supply rail with its two threshold comparators
`timescale 1ns/1ps
module smps_rail_model import smps_pkg::*; #(
  parameter int LOW_LVL = 20,
  parameter int ON_LVL = 40,
  parameter int TOP_LVL = 48
) (
  input wire logic clk,
  input wire logic [1:0] hv_charge_source,
  input wire logic gate_enable,
  output logic vcc_above_low_supply,
  output logic vcc_above_turn_on
);
  int vcc = 0;
  // Charge source or switching lifts the rail, idle load drains it
  always_ff @(posedge clk) begin
    if ((hv_charge_source != CHG_OFF || gate_enable) && vcc < TOP_LVL)
      vcc <= vcc + ((hv_charge_source == CHG_HIGH) ? 2 : 1);
    else if (hv_charge_source == CHG_OFF && !gate_enable && vcc > 0)
      vcc <= vcc - 1;
  end
  assign vcc_above_low_supply = vcc >= LOW_LVL;
  assign vcc_above_turn_on = vcc >= ON_LVL;
endmodule

// ==== smps_seq_chk.sv ====
// Port-level assertions for the startup and protection sequencer
`timescale 1ns/1ps
module smps_seq_chk import smps_pkg::*; #(
  parameter int RAMP_COUNT = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic input_start_ok,
  input wire logic vcc_above_low_supply,
  input wire logic vcc_above_turn_on,
  input wire logic optocoupler_input_above_disable,
  input wire logic overcurrent_flag,
  input wire logic input_surge_flag,
  input wire logic [1:0] hv_charge_source,
  input wire logic gate_enable,
  input wire smps_mode_e mode
);
  int ramp_cnt;
  // Ramp length counted here, a repetition that long would not unroll
  always_ff @(posedge clk) begin
    if (sys_rst || mode != SMPS_RAMP) ramp_cnt <= 0;
    else ramp_cnt <= ramp_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Startup steps of the charge source
  sequence s_rail_low;
    mode == SMPS_STARTUP && input_start_ok && !vcc_above_low_supply;
  endsequence
  sequence s_rail_mid;
    mode == SMPS_STARTUP && input_start_ok && vcc_above_low_supply &&
      !vcc_above_turn_on;
  endsequence
  property p_off_below;
    !input_start_ok && !$past(input_start_ok) |-> hv_charge_source == CHG_OFF;
  endproperty
  property p_reduced;
    s_rail_low ##1 mode == SMPS_STARTUP |-> hv_charge_source == CHG_REDUCED;
  endproperty
  property p_high;
    s_rail_mid ##1 mode == SMPS_STARTUP |-> hv_charge_source == CHG_HIGH;
  endproperty
  property p_off_run;
    mode inside {SMPS_RAMP, SMPS_ACTIVE, SMPS_STOP} |-> hv_charge_source == 0;
  endproperty
  property p_kill;
    overcurrent_flag || input_surge_flag |-> !gate_enable;
  endproperty
  property p_oc_stop;
    mode == SMPS_ACTIVE && overcurrent_flag |=> mode == SMPS_STOP;
  endproperty
  property p_surge;
    input_surge_flag && mode != SMPS_LOWC |=> mode == SMPS_STOP;
  endproperty
  property p_optocoupler_input_low;
    !optocoupler_input_above_disable && !input_surge_flag && !overcurrent_flag &&
      mode inside {SMPS_ACTIVE, SMPS_STOP} |=> mode == SMPS_LOWC;
  endproperty
  property p_lowc_on;
    $rose(mode == SMPS_LOWC) && $past(input_start_ok) &&
      !$past(vcc_above_turn_on) |-> hv_charge_source != CHG_OFF;
  endproperty
  property p_ramp_len;
    mode == SMPS_ACTIVE && $past(mode) == SMPS_RAMP |->
      $past(ramp_cnt) inside {[RAMP_COUNT - 2:RAMP_COUNT]};
  endproperty
  a_off_below: assert property (p_off_below)
    else $error("charge source on below start level");
  a_reduced: assert property (p_reduced)
    else $error("reduced current missing");
  a_high: assert property (p_high)
    else $error("high current missing");
  a_off_run: assert property (p_off_run)
    else $error("charge source on while running");
  a_kill: assert property (p_kill)
    else $error("gate not killed");
  a_oc_stop: assert property (p_oc_stop)
    else $error("no stop after overcurrent");
  a_surge: assert property (p_surge)
    else $error("no stop after surge");
  a_optocoupler_input_low: assert property (p_optocoupler_input_low)
    else $error("optocoupler_input low did not give low consumption");
  a_lowc_on: assert property (p_lowc_on)
    else $error("charge source off on low consumption entry");
  a_ramp_len: assert property (p_ramp_len)
    else $error("ramp length wrong");
endmodule
bind smps_sequencer smps_seq_chk #(.RAMP_COUNT(RAMP_COUNT)) chk_u (.clk,
  .sys_rst, .input_start_ok, .vcc_above_low_supply, .vcc_above_turn_on,
  .optocoupler_input_above_disable, .overcurrent_flag, .input_surge_flag,
  .hv_charge_source, .gate_enable, .mode);

// ==== smps_sequencer.sv ====
// Startup, mode and protection sequencer of an offline converter controller
// Operating notes
// Modes: startup, ramp-up, active, stop and low-consumption.
// Every interval lasts exactly its terminal count in clock cycles.
// The restart timer unit restarts from one on each mode change.
// That makes a terminal of N give a spell of N cycles, not N plus one.
// Surge holds stop for as long as the flag stands, then times restart.
// Overcurrent stop uses its own short interval; brownout the restart one.
// Over-power and brownout counters only run in active mode.
// Ramp-up therefore never trips them, however long the flags stand.
// Brownout samples are taken in on-time only; off-time holds the count.
// A clean on-time sample clears the brownout count at once.
// Over-power count clears on any cycle without the flag.
// Surge is blanked only in low-consumption mode: it is checked after every other transition.
// Surge and overcurrent also kill the gate without waiting for a clock.
// That costs a combinational path from two comparator pins to the gate.
// The charge source is registered from the next mode.
// It changes at the same edge as the mode, with no lag behind it.
// Input below start threshold forces the charge source off in any mode.
// A rail below the low supply level gets the reduced current whenever the next mode is startup or low-consumption.
// This guard is kept in low-consumption mode too, for a shorted pin.
// Low-consumption charging starts on the entry edge itself.
// It then follows the low and turn-on thresholds as a hysteretic loop.
// Startup after a low-consumption spell goes straight to active.
// Soft disable acts like the optocoupler pin; software enable does too, except in stop mode.
// Event bits are sticky; a new event wins over a same-cycle clear.
// The register bus inserts exactly one wait cycle on every access.
// Comparator inputs are taken as synchronous to the clock.
`timescale 1ns/1ps
module smps_sequencer #(
  parameter int RAMP_COUNT = smps_pkg::RAMP_CYCLES,
  parameter int OVERCURRENT_STOP_COUNT = smps_pkg::OVERCURRENT_STOP_CYCLES,
  parameter int BROWNOUT_QUAL_COUNT = smps_pkg::BROWNOUT_QUAL_CYCLES,
  parameter int OVER_POWER_QUAL_COUNT = smps_pkg::OVER_POWER_QUAL_CYCLES,
  parameter int RESTART_COUNT = smps_pkg::RESTART_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog comparator flags
  input wire logic input_start_ok,
  input wire logic vcc_above_low_supply,
  input wire logic vcc_above_turn_on,
  input wire logic optocoupler_input_above_disable,
  input wire logic feedback_in_range,
  input wire logic overcurrent_flag,
  input wire logic input_surge_flag,
  input wire logic gate_on_time,
  input wire logic clamp_below_brownout_min,
  input wire logic over_power_flag,
  input wire logic output_sense_high,
  // Outputs to the power stage
  output logic [1:0] hv_charge_source,
  output logic gate_enable,
  output logic output_overshoot_limit,
  output smps_pkg::smps_mode_e mode
);
  import smps_pkg::*;

  smps_mode_e next_mode;
  logic [TIMER_W-1:0] restart_timer_unit;
  logic [TIMER_W-1:0] stop_target;
  logic [TIMER_W-1:0] brownout_count;
  logic [TIMER_W-1:0] over_power_count;
  logic lowc_charging;
  logic after_lowc;
  logic [31:0] ctrl;
  logic [4:0] events;
  logic [4:0] next_events;
  logic ack;
  logic brownout_trip;
  logic over_power_trip;
  logic sw_enable;
  logic optocoupler_input_disable;

  // Count that saturates at all ones, shared by every interval
  function automatic logic [TIMER_W-1:0] bump(input logic [TIMER_W-1:0] c);
    bump = (c == '1) ? c : c + 1'b1;
  endfunction

  function automatic logic [TIMER_W-1:0] term(input int n);
    term = TIMER_W'(n);
  endfunction

  assign sw_enable = ctrl[CTRL_ENABLE_BIT];
  // Outside party pulls optocoupler_input low, or software asks for the same effect
  assign optocoupler_input_disable = !optocoupler_input_above_disable || ctrl[CTRL_SOFT_DISABLE_BIT];


  // Brownout qualifies only from samples taken in on-time, in active mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brownout_count <= '0;
    end else if (mode != SMPS_ACTIVE) begin
      brownout_count <= '0;
    end else if (gate_on_time) begin
      if (clamp_below_brownout_min) begin
        brownout_count <= bump(brownout_count);
      end else begin
        brownout_count <= '0;
      end
    end
  end
  assign brownout_trip = (brownout_count >= term(BROWNOUT_QUAL_COUNT));

  // Over-power qualification; blanked outside active mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      over_power_count <= '0;
    end else if (mode != SMPS_ACTIVE) begin
      over_power_count <= '0;
    end else if (over_power_flag) begin
      over_power_count <= bump(over_power_count);
    end else begin
      over_power_count <= '0;
    end
  end
  assign over_power_trip =
    (over_power_count >= term(OVER_POWER_QUAL_COUNT));


  // Mode transitions; surge is checked in every mode but low-consumption, overcurrent in ramp and active only
  always_comb begin
    next_mode = mode;
    unique case (mode)
      SMPS_STARTUP: begin
        if (vcc_above_turn_on && !optocoupler_input_disable && feedback_in_range &&
            sw_enable) begin
          next_mode = after_lowc ? SMPS_ACTIVE : SMPS_RAMP;
        end
      end
      SMPS_RAMP: begin
        if (restart_timer_unit >= term(RAMP_COUNT)) begin
          next_mode = SMPS_ACTIVE;
        end
      end
      SMPS_ACTIVE: begin
        if (over_power_trip) begin
          next_mode = SMPS_LOWC;
        end else if (brownout_trip) begin
          next_mode = SMPS_STOP;
        end
      end
      SMPS_STOP: begin
        if (restart_timer_unit >= stop_target) begin
          next_mode = SMPS_STARTUP;
        end
      end
      SMPS_LOWC: begin
        if (restart_timer_unit >= term(RESTART_COUNT) && !optocoupler_input_disable &&
            sw_enable) begin
          next_mode = SMPS_STARTUP;
        end
      end
    endcase
    if (mode inside {SMPS_RAMP, SMPS_ACTIVE}) begin
      if (optocoupler_input_disable || !vcc_above_low_supply || !sw_enable) begin
        next_mode = SMPS_LOWC;
      end
    end
    if (mode == SMPS_STOP && (optocoupler_input_disable || !vcc_above_low_supply)) begin
      next_mode = SMPS_LOWC;
    end
    if (input_surge_flag && mode != SMPS_LOWC) begin
      next_mode = SMPS_STOP;
    end else if (overcurrent_flag &&
                 mode inside {SMPS_RAMP, SMPS_ACTIVE}) begin
      next_mode = SMPS_STOP;
    end
  end


  // Mode register; timer starts at one so a terminal N lasts N cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= SMPS_STARTUP;
      restart_timer_unit <= '0;
      stop_target <= '0;
    end else begin
      mode <= next_mode;
      if (next_mode != mode) begin
        restart_timer_unit <= TIMER_W'(1);
      end else if (mode == SMPS_STOP && input_surge_flag) begin
        restart_timer_unit <= TIMER_W'(1); // Hold stop while surge persists
      end else begin
        restart_timer_unit <= bump(restart_timer_unit);
      end
      if (next_mode == SMPS_STOP && mode != SMPS_STOP) begin
        stop_target <= (input_surge_flag || brownout_trip) ?
                       term(RESTART_COUNT) :
                       term(OVERCURRENT_STOP_COUNT);
      end
    end
  end


  // Remember whether startup follows a low-consumption spell
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      after_lowc <= 1'b0;
    end else if (mode == SMPS_LOWC) begin
      after_lowc <= 1'b1;
    end else if (mode == SMPS_ACTIVE) begin
      after_lowc <= 1'b0;
    end
  end


  // Hysteretic charging in low-consumption mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowc_charging <= 1'b0;
    end else if (mode != SMPS_LOWC && next_mode == SMPS_LOWC) begin
      lowc_charging <= 1'b1;
    end else if (mode == SMPS_LOWC) begin
      if (vcc_above_turn_on) begin
        lowc_charging <= 1'b0;
      end else if (!vcc_above_low_supply) begin
        lowc_charging <= 1'b1;
      end
    end else begin
      lowc_charging <= 1'b0;
    end
  end


  // Charge source selection; input below start threshold overrides all
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hv_charge_source <= CHG_OFF;
    end else if (!input_start_ok) begin
      hv_charge_source <= CHG_OFF;
    end else begin
      unique case (next_mode)
        SMPS_STARTUP: begin
          if (!vcc_above_low_supply) begin
            hv_charge_source <= CHG_REDUCED;
          end else if (!vcc_above_turn_on) begin
            hv_charge_source <= CHG_HIGH;
          end else begin
            hv_charge_source <= CHG_OFF;
          end
        end
        SMPS_LOWC: begin
          if (!vcc_above_low_supply) begin
            hv_charge_source <= CHG_REDUCED; // Short-pin guard kept
          end else if ((lowc_charging || mode != SMPS_LOWC) &&
                       !vcc_above_turn_on) begin
            hv_charge_source <= CHG_HIGH;
          end else begin
            hv_charge_source <= CHG_OFF;
          end
        end
        default: hv_charge_source <= CHG_OFF;
      endcase
    end
  end


  // Gate permission: combinational kill so overcurrent and surge act at once
  logic gate_allow;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_allow <= 1'b0;
    end else begin
      gate_allow <= next_mode inside {SMPS_RAMP, SMPS_ACTIVE};
    end
  end
  assign gate_enable = gate_allow && !overcurrent_flag &&
                       !input_surge_flag;


  // Extra feedback sink while output sense is well above reference, in ramp and active modes only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_overshoot_limit <= 1'b0;
    end else begin
      output_overshoot_limit <= output_sense_high &&
                                mode inside {SMPS_RAMP, SMPS_ACTIVE};
    end
  end


  // Sticky event bits; a new event wins over a same-cycle clear
  always_comb begin
    next_events = events;
    if (ack && avs_write && avs_address == REG_EVENTS &&
        avs_byteenable[0]) begin
      next_events = events & ~avs_writedata[4:0];
    end
    next_events = next_events | {over_power_trip && mode == SMPS_ACTIVE,
                                 brownout_trip && mode == SMPS_ACTIVE,
                                 input_surge_flag,
                                 overcurrent_flag && gate_allow,
                                 mode == SMPS_LOWC};
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      events <= '0;
    end else begin
      events <= next_events;
    end
  end


  // Avalon slave: one wait cycle, then the access completes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;


  // Control register with byte enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (ack && avs_write && avs_address == REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          ctrl[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end


  // Read data captured at the wait cycle so it stands at the ack edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      unique case (avs_address)
        REG_CTRL: avs_readdata <= {30'h0, ctrl[1:0]};
        REG_STATUS: avs_readdata <= {24'h0, gate_enable,
                                     output_overshoot_limit,
                                     hv_charge_source, 1'b0, mode};
        REG_EVENTS: avs_readdata <= {27'h0, events};
        REG_TIMER: avs_readdata <= {8'h0, restart_timer_unit};
        default: avs_readdata <= '0;
      endcase
    end
  end
endmodule

// ==== tb_smps_sequencer.sv ====
// Self-checking bench for the startup and protection sequencer
`timescale 1ns/1ps
module tb_smps_sequencer;
  import smps_pkg::*;
  localparam int RAMP_N = 16;
  localparam int STOP_N = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic input_start_ok = 1'b0, optocoupler_input_above_disable = 1'b1;
  logic feedback_in_range = 1'b0, overcurrent_flag = 1'b0;
  logic input_surge_flag = 1'b0, gate_on_time = 1'b0;
  logic clamp_below_brownout_min = 1'b0, over_power_flag = 1'b0;
  logic output_sense_high = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, vcc_above_low_supply, vcc_above_turn_on;
  logic gate_enable, output_overshoot_limit;
  logic [1:0] hv_charge_source;
  smps_mode_e mode;
  int bad_count = 0, tests_run = 0, cycles = 0, seed = 70024, n;
  smps_sequencer #(.RAMP_COUNT(RAMP_N), .OVERCURRENT_STOP_COUNT(STOP_N),
    .BROWNOUT_QUAL_COUNT(8), .OVER_POWER_QUAL_COUNT(8),
    .RESTART_COUNT(16)) dut_u (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .input_start_ok,
    .vcc_above_low_supply, .vcc_above_turn_on, .optocoupler_input_above_disable,
    .feedback_in_range, .overcurrent_flag, .input_surge_flag, .gate_on_time,
    .clamp_below_brownout_min, .over_power_flag, .output_sense_high,
    .hv_charge_source, .gate_enable, .output_overshoot_limit, .mode);
  smps_rail_model rail_u (.clk, .hv_charge_source, .gate_enable,
    .vcc_above_low_supply, .vcc_above_turn_on);
  // Free-running clock
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Counts the cycles spent in one mode, started inside its first cycle
  task automatic span(input smps_mode_e m);
    n = 0;
    while (mode == m) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Avalon cycle: held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cycle ceiling so that a stuck wait still reaches the report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    cyc(3);
    chk(hv_charge_source, CHG_OFF);
    @(posedge clk) input_start_ok <= 1'b1;
    cyc(3);
    chk(hv_charge_source, CHG_REDUCED);
    wait (vcc_above_low_supply);
    cyc(2);
    chk(hv_charge_source, CHG_HIGH);
    wait (vcc_above_turn_on);
    cyc(4);
    chk(mode, SMPS_STARTUP);
    @(posedge clk) feedback_in_range <= 1'b1;
    wait (mode == SMPS_RAMP);
    @(negedge clk);
    chk(hv_charge_source, CHG_OFF);
    span(SMPS_RAMP);
    chk(n, RAMP_N);
    $display("startup done");
    @(posedge clk) output_sense_high <= 1'b1;
    cyc(2);
    chk(output_overshoot_limit, 1'b1);
    @(posedge clk) output_sense_high <= 1'b0;
    @(posedge clk) overcurrent_flag <= 1'b1;
    @(negedge clk);
    chk(gate_enable, 1'b0);
    @(posedge clk) overcurrent_flag <= 1'b0;
    @(negedge clk);
    span(SMPS_STOP);
    chk(n, STOP_N);
    $display("overcurrent done");
    wait (mode == SMPS_ACTIVE);
    n = 2 + ($random(seed) & 3);
    @(posedge clk) input_surge_flag <= 1'b1;
    @(negedge clk);
    chk(gate_enable, 1'b0);
    repeat (n) @(posedge clk);
    input_surge_flag <= 1'b0;
    @(negedge clk);
    chk(mode, SMPS_STOP);
    wait (mode == SMPS_ACTIVE);
    bus(1'b0, REG_EVENTS, 32'h0);
    chk(rd, 32'h6);
    bus(1'b1, REG_EVENTS, 32'h6);
    bus(1'b0, REG_EVENTS, 32'h0);
    chk(rd, 32'h0);
    $display("surge done");
    @(posedge clk) over_power_flag <= 1'b1;
    repeat (12) @(posedge clk) gate_on_time <= 1'($random(seed));
    over_power_flag <= 1'b0;
    @(negedge clk);
    chk(mode, SMPS_LOWC);
    wait (mode == SMPS_ACTIVE);
    $display("over power done");
    @(posedge clk);
    clamp_below_brownout_min <= 1'b1;
    gate_on_time <= 1'b1;
    cyc(12);
    chk(mode, SMPS_STOP);
    @(posedge clk) clamp_below_brownout_min <= 1'b0;
    wait (!vcc_above_turn_on);
    @(posedge clk) optocoupler_input_above_disable <= 1'b0;
    cyc(2);
    chk(mode, SMPS_LOWC);
    chk(hv_charge_source, CHG_HIGH);
    @(posedge clk) optocoupler_input_above_disable <= 1'b1;
    wait (mode == SMPS_ACTIVE);
    $display("brownout and disable done");
    finish_test();
  end
endmodule
